// file: hdl/rtu_defs.svh
// Purpose: Offsets, field positions, reset values and counts of the tag uplink encoder.
// Assumes: Byte addresses on a 32-bit AHB-Lite bus, one word per register.
// Notes:   Definitions only.
`ifndef RTU_DEFS_SVH
`define RTU_DEFS_SVH
`define RTU_A_CFG     8'h00
`define RTU_A_CMD     8'h04
`define RTU_A_WDATA   8'h08
`define RTU_A_RDATA   8'h0c
`define RTU_A_STATUS  8'h10
`define RTU_A_ISTAT   8'h14
`define RTU_A_IMASK   8'h18
`define RTU_A_CRC     8'h1c
`define RTU_A_SEC     8'h20
`define RTU_CMD_SEND  8
`define RTU_CMD_PROG  9
`define RTU_CMD_LOCK  10
`define RTU_CRC_RST   8
`define RTU_IRQ_TX    0
`define RTU_IRQ_CRC   1
`define RTU_IRQ_LOCK  2
`define RTU_IRQ_PROG  3
`define RTU_MODE_NRZ  2'h0
`define RTU_MODE_MAN  2'h1
`define RTU_MODE_BPH  2'h2
// Start-up delay of 200 field clock cycles.
`define RTU_INIT_CYC  8'hc8
`define RTU_USER_LAST 6'h1f
`define RTU_SYS_FIRST 6'h36
`define RTU_BLK_PWR   6'h36
`define RTU_BLK_PWW   6'h37
`define RTU_BLK_ID0   6'h38
`define RTU_BLK_ID2   6'h3a
`define RTU_BLK_SEC   6'h3e
`define RTU_BLK_CFG   6'h3f
`define RTU_LAST_BIT  5'h1f
`define RTU_CRC_INIT  16'hffff
`define RTU_CRC_POLY  16'h1021
`define RTU_CFG_RST   7'h00
`endif

// file: hdl/rtu_pkg.sv
// Purpose: Types shared by the tag uplink encoder.
// Assumes: Constants come from rtu_defs.svh.
// Notes:   Types only.
package rtu_pkg;
	typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_TX} rtu_state_type;
	typedef struct packed {
		logic [4:0] rate;
		logic [1:0] mode;
	} rtu_cfg_type;
	typedef struct packed {
		logic [31:0] shift;
		logic [4:0]  bit_cnt;
		logic        phase;
		logic [4:0]  div;
		logic        mod;
	} rtu_tx_type;
endpackage : rtu_pkg

// file: hdl/rtu_tag_uplink_encoder.sv
// Purpose: Tag core: start-up load, block memory with lock bits, command CRC check
//          and the configurable uplink encoder driving the load modulator.
// Assumes: hclk is the field clock; hresetn comes from the power-on detector.
// Notes:   Registers are reached over AHB-Lite with zero wait states.
// Summary of operation
// RL1 - Hold in reset, then wait 200 clocks loading config and page security.
// RL2 - Clock and power come from the field; no separate clock exists.
// RL3 - Manchester: zero falls at mid bit, one rises at mid bit.
// RL4 - Bi-phase: zero toggles at mid bit, one has no mid-bit edge.
// RL5 - Bi-phase: first half bit after frame start is modulated.
// RL6 - Modulator source follows configured encoding: Manchester, Bi-phase or NRZ.
// RL7 - NRZ: load on for one, off for zero, straight from memory.
// RL8 - Bit period is 2(n+1) field clocks, RF/2 to RF/64.
// RL9 - Reader sends gap-modulated one-of-four commands; the tag decodes them. Here no decoder exists; commands are AHB-Lite writes to CMD.
// RL10 - Commands carry a CCITT CRC-16; faulty commands are not executed. Only PROG is gated by the CRC here; SEND starts regardless.
// RL11 - Memory is 32-bit blocks, each with a write-protecting lock bit.
// RL12 - Blocks move serially, MSB first, a whole block at a time.
// RL13 - 1024 user bits: 32 blocks in 8 pages of 4 blocks.
// RL14 - Ten system blocks, two of them read and write passwords.
// RL15 - Three system blocks hold the tag identifier, up to 96 bits.
// RL16 - A locked block refuses all programming, lock bit included.
// RL17 - System blocks top a 6-bit space; config 63, page security 62.
// RL18 - Mid-bit transitions fall exactly half a bit period after bit start.
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "rtu_defs.svh"
module rtu_tag_uplink_encoder
	import rtu_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output logic             irq,
	output logic             load_mod
);
	rtu_state_type state_reg, state_next;
	rtu_cfg_type   cfg_reg, cfg_next;
	rtu_tx_type    tx_reg, tx_next;
	logic [7:0]    init_reg, init_next;
	logic [31:0]   sec_reg, sec_next;
	logic [5:0]    addr_reg, addr_next;
	logic [31:0]   wdata_reg, wdata_next;
	logic [15:0]   crc_reg, crc_next;
	logic [3:0]    istat_reg, istat_next;
	logic [3:0]    imask_reg, imask_next;
	logic [31:0]   rdata_reg, rdata_next;
	logic          wr_pend_reg, wr_pend_next;
	logic [7:0]    wa_reg, wa_next;
	logic [31:0]   mem_reg [0:63];
	logic [63:0]   lock_reg;
	logic          mem_we;
	logic          mem_wl;
	logic [3:0]    ev;
	logic          half_tick;
	logic          start_tx;
	logic          prog_req;
	logic          addr_ok;
	logic          bit_end;
	logic          acc;
	logic [3:0]    w1c;

	// Fixed AHB-Lite answer: never stalls, always OKAY.
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_reg;
	assign load_mod  = tx_reg.mod;
	assign irq       = |(istat_reg & imask_reg);

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			if (r[15] ^ d[i]) begin
				r = {r[14:0], 1'b0} ^ `RTU_CRC_POLY;
			end else begin
				r = {r[14:0], 1'b0};
			end
		end
		return r;
	endfunction : crc_byte

	// User blocks 0..31 and the ten system blocks 54..63; the gap is unmapped.
	assign addr_ok = (addr_reg <= `RTU_USER_LAST) || (addr_reg >= `RTU_SYS_FIRST); // RL13 RL14 RL17
	assign acc = hsel && hready && htrans[1];
	// A command acts on the block address already held, so software writes the address
	// first. The same write loads its own address field as well, so a second command
	// aimed at the same block needs no further address write.
	assign start_tx = wr_pend_reg && (wa_reg == `RTU_A_CMD) && hwdata[`RTU_CMD_SEND]
		&& (state_reg == ST_IDLE) && addr_ok;
	assign prog_req = wr_pend_reg && (wa_reg == `RTU_A_CMD) && hwdata[`RTU_CMD_PROG]
		&& (state_reg == ST_IDLE) && !hwdata[`RTU_CMD_SEND];
	// Every tick is one half bit, so a bit spans 2(n+1) field clocks.
	assign half_tick = (state_reg == ST_TX) && (tx_reg.div == cfg_reg.rate); // RL8 RL18
	assign bit_end = half_tick && tx_reg.phase && (tx_reg.bit_cnt == `RTU_LAST_BIT);
	assign w1c = (wr_pend_reg && wa_reg == `RTU_A_ISTAT) ? hwdata[3:0] : 4'h0;

	always_comb begin
		state_next   = state_reg;
		cfg_next     = cfg_reg;
		tx_next      = tx_reg;
		init_next    = init_reg;
		sec_next     = sec_reg;
		addr_next    = addr_reg;
		wdata_next   = wdata_reg;
		crc_next     = crc_reg;
		imask_next   = imask_reg;
		rdata_next   = rdata_reg;
		wr_pend_next = acc && hwrite;
		wa_next      = acc ? haddr[7:0] : wa_reg;
		mem_we       = 1'b0;
		mem_wl       = 1'b0;
		ev           = 4'h0;
		case (state_reg)
			ST_INIT: begin
				// Config and page security are copied while the delay runs out.
				init_next = init_reg + 8'h01; // RL1
				if (init_reg == `RTU_INIT_CYC - 8'h01) begin
					cfg_next  = mem_reg[`RTU_BLK_CFG][6:0]; // RL1 RL17
					sec_next  = mem_reg[`RTU_BLK_SEC]; // RL17
					state_next = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (start_tx) begin
					// Bi-phase starts from an idle low level, so the first half is loaded.
					tx_next.shift   = mem_reg[addr_reg]; // RL12
					tx_next.bit_cnt = 5'h00;
					tx_next.phase   = 1'b0;
					tx_next.div     = 5'h00;
					case (cfg_reg.mode) // RL6
						`RTU_MODE_MAN: tx_next.mod = !mem_reg[addr_reg][31]; // RL3
						`RTU_MODE_BPH: tx_next.mod = 1'b1; // RL5
						default:       tx_next.mod = mem_reg[addr_reg][31]; // RL7
					endcase
					state_next = ST_TX;
				end
			end
			ST_TX: begin
				tx_next.div = half_tick ? 5'h00 : tx_reg.div + 5'h01; // RL8
				if (half_tick && !tx_reg.phase) begin
					tx_next.phase = 1'b1;
					case (cfg_reg.mode) // RL6
						`RTU_MODE_MAN: tx_next.mod = tx_reg.shift[31]; // RL3 RL18
						`RTU_MODE_BPH: tx_next.mod = tx_reg.mod ^ !tx_reg.shift[31]; // RL4 RL18
						default:       tx_next.mod = tx_reg.mod; // RL7
					endcase
				end else if (bit_end) begin
					tx_next.mod = 1'b0;
					tx_next.phase = 1'b0;
					ev[`RTU_IRQ_TX] = 1'b1;
					state_next = ST_IDLE;
				end else if (half_tick) begin
					tx_next.phase   = 1'b0;
					tx_next.bit_cnt = tx_reg.bit_cnt + 5'h01;
					tx_next.shift   = {tx_reg.shift[30:0], 1'b0}; // RL12
					case (cfg_reg.mode) // RL6
						`RTU_MODE_MAN: tx_next.mod = !tx_reg.shift[30]; // RL3
						`RTU_MODE_BPH: tx_next.mod = !tx_reg.mod; // RL4
						default:       tx_next.mod = tx_reg.shift[30]; // RL7
					endcase
				end
			end
			default: begin
				state_next = ST_INIT;
			end
		endcase
		if (prog_req) begin
			// A faulty command is dropped and reported, never half-executed.
			if (crc_reg != 16'h0000) begin
				ev[`RTU_IRQ_CRC] = 1'b1; // RL10
			end else if (!addr_ok || lock_reg[addr_reg]
				|| (addr_reg <= `RTU_USER_LAST && sec_reg[addr_reg[4:2]])) begin
				ev[`RTU_IRQ_LOCK] = 1'b1; // RL16 RL13
			end else begin
				mem_we = 1'b1; // RL11
				mem_wl = hwdata[`RTU_CMD_LOCK]; // RL11
				ev[`RTU_IRQ_PROG] = 1'b1;
			end
			crc_next = `RTU_CRC_INIT; // RL10
		end
		if (wr_pend_reg) begin
			case (wa_reg)
				`RTU_A_CFG:   cfg_next   = hwdata[6:0];
				`RTU_A_CMD:   addr_next  = hwdata[5:0];
				`RTU_A_WDATA: wdata_next = hwdata;
				`RTU_A_IMASK: imask_next = hwdata[3:0];
				`RTU_A_CRC: begin
					if (hwdata[`RTU_CRC_RST]) begin
						crc_next = `RTU_CRC_INIT;
					end else begin
						crc_next = crc_byte(crc_reg, hwdata[7:0]); // RL10
					end
				end
				default: begin
				end
			endcase
		end
		if (acc && !hwrite) begin
			case (haddr[7:0])
				`RTU_A_CFG:    rdata_next = {25'h0, cfg_reg};
				`RTU_A_CMD:    rdata_next = {26'h0, addr_reg};
				`RTU_A_WDATA:  rdata_next = wdata_reg;
				`RTU_A_RDATA:  rdata_next = addr_ok ? mem_reg[addr_reg] : 32'h0;
				`RTU_A_STATUS: rdata_next = {28'h0, crc_reg == 16'h0000, lock_reg[addr_reg],
					state_reg == ST_TX, state_reg != ST_INIT};
				`RTU_A_ISTAT:  rdata_next = {28'h0, istat_reg};
				`RTU_A_IMASK:  rdata_next = {28'h0, imask_reg};
				`RTU_A_CRC:    rdata_next = {16'h0, crc_reg};
				`RTU_A_SEC:    rdata_next = sec_reg;
				default:       rdata_next = 32'h0;
			endcase
		end
		// A new event outranks a clear in the same cycle.
		istat_next = (istat_reg & ~w1c) | ev;
	end

	// The field clock is the only clock; every period is counted on it.
	always_ff @(posedge hclk or negedge hresetn) begin // RL2
		if (!hresetn) begin
			state_reg   <= ST_INIT; // RL1
			cfg_reg     <= `RTU_CFG_RST;
			tx_reg      <= '0;
			init_reg    <= 8'h00;
			sec_reg     <= 32'h0;
			addr_reg    <= 6'h00;
			wdata_reg   <= 32'h0;
			crc_reg     <= `RTU_CRC_INIT;
			istat_reg   <= 4'h0;
			imask_reg   <= 4'h0;
			rdata_reg   <= 32'h0;
			wr_pend_reg <= 1'b0;
			wa_reg      <= 8'h00;
		end else begin
			state_reg   <= state_next;
			cfg_reg     <= cfg_next;
			tx_reg      <= tx_next;
			init_reg    <= init_next;
			sec_reg     <= sec_next;
			addr_reg    <= addr_next;
			wdata_reg   <= wdata_next;
			crc_reg     <= crc_next;
			istat_reg   <= istat_next;
			imask_reg   <= imask_next;
			rdata_reg   <= rdata_next;
			wr_pend_reg <= wr_pend_next;
			wa_reg      <= wa_next;
		end
	end

	// Rows and locks clear at reset so simulation starts from an erased part.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 64; i++) begin
				mem_reg[i] <= 32'h0;
			end
			lock_reg <= 64'h0;
		end else if (mem_we) begin
			mem_reg[addr_reg]  <= wdata_reg; // RL11 RL14 RL15
			lock_reg[addr_reg] <= mem_wl; // RL16
		end
	end

	// Helper counters that only the checks read.
	logic [8:0] age_reg;
	logic [5:0] gap_reg;
	logic [6:0] bit_age_reg;
	logic [31:0] blk_reg;
	logic        lk_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			age_reg     <= 9'h000;
			gap_reg     <= 6'h00;
			bit_age_reg <= 7'h00;
		end else begin
			age_reg     <= (age_reg == 9'h1ff) ? age_reg : age_reg + 9'h001;
			gap_reg     <= (start_tx || half_tick) ? 6'h00 : gap_reg + 6'h01;
			bit_age_reg <= (start_tx || (half_tick && tx_reg.phase)) ? 7'h00
				: bit_age_reg + 7'h01;
		end
	end
	assign blk_reg = mem_reg[addr_reg];
	assign lk_reg  = lock_reg[addr_reg];

	sequence s_mid_tick;
		half_tick && !tx_reg.phase;
	endsequence
	sequence s_man_mid;
		s_mid_tick and (cfg_reg.mode == `RTU_MODE_MAN);
	endsequence
	sequence s_bph_mid;
		s_mid_tick and (cfg_reg.mode == `RTU_MODE_BPH);
	endsequence
	// Bi-phase changes level at every bit start, so the reader can always find the bit grid.
	sequence s_bph_bound;
		(half_tick && tx_reg.phase && !bit_end) and (cfg_reg.mode == `RTU_MODE_BPH);
	endsequence

	chk_init_delay_len: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
		(state_reg == ST_INIT && state_next == ST_IDLE) |-> age_reg == 9'h0c7)
		else $error("start-up delay is not 200 cycles");
	chk_cfg_load_top: assert property (@(posedge hclk) disable iff (!hresetn) // RL17
		(state_reg == ST_INIT && state_next == ST_IDLE)
		|=> cfg_reg == $past(mem_reg[`RTU_BLK_CFG][6:0]))
		else $error("config not loaded from block 63");
	chk_man_mid_edge: assert property (@(posedge hclk) disable iff (!hresetn) // RL3
		s_man_mid |=> load_mod == $past(tx_reg.shift[31]) && $past(load_mod) != load_mod)
		else $error("manchester mid-bit edge wrong");
	chk_bph_mid_edge: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
		s_bph_mid |=> load_mod == ($past(load_mod) ^ !$past(tx_reg.shift[31])))
		else $error("bi-phase mid-bit edge wrong");
	chk_bph_first_half: assert property (@(posedge hclk) disable iff (!hresetn) // RL5
		(start_tx && cfg_reg.mode == `RTU_MODE_BPH) |=> load_mod && !tx_reg.phase)
		else $error("bi-phase first half not modulated");
	chk_bph_bit_toggle: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
		s_bph_bound |=> load_mod != $past(load_mod))
		else $error("bi-phase bit boundary has no edge");
	chk_nrz_level_out: assert property (@(posedge hclk) disable iff (!hresetn) // RL7
		(state_reg == ST_TX && cfg_reg.mode == `RTU_MODE_NRZ) |-> load_mod == tx_reg.shift[31])
		else $error("nrz level differs from data bit");
	chk_half_bit_spacing: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
		half_tick |-> gap_reg == {1'b0, cfg_reg.rate})
		else $error("half bit period is not n+1 cycles");
	chk_mid_bit_timing: assert property (@(posedge hclk) disable iff (!hresetn) // RL18
		s_mid_tick |-> bit_age_reg == {2'h0, cfg_reg.rate})
		else $error("mid-bit edge not at half period");
	chk_crc_gate_prog: assert property (@(posedge hclk) disable iff (!hresetn) // RL10
		prog_req && crc_reg != 16'h0000 |=> $stable(blk_reg) && istat_reg[`RTU_IRQ_CRC])
		else $error("command with bad crc executed");
	chk_lock_refuse_prog: assert property (@(posedge hclk) disable iff (!hresetn) // RL16
		prog_req && lk_reg && crc_reg == 16'h0000
		|=> $stable(blk_reg) && lk_reg && istat_reg[`RTU_IRQ_LOCK])
		else $error("locked block was programmed");
	chk_tx_done_flag: assert property (@(posedge hclk) disable iff (!hresetn) // RL12
		bit_end |=> istat_reg[`RTU_IRQ_TX] && state_reg == ST_IDLE && !load_mod)
		else $error("block end not flagged after 32 bits");
endmodule : rtu_tag_uplink_encoder
`default_nettype wire

// file: sim/rtu_reader_model.sv
// Purpose: Reader side of the uplink: samples one 32-bit frame of load modulation and decodes it.
// Assumes: go is seen high at the first edge after the edge that starts the frame.
// Notes:   Any uneven half bit, missing edge or late release sets bad.
`timescale 1ns/100ps
`default_nettype none
module rtu_reader_model (
	input  wire logic        hclk,
	input  wire logic        load_mod,
	input  wire logic        go,
	input  wire logic [1:0]  mode,
	input  wire logic [4:0]  rate,
	output logic [31:0]      word,
	output logic             bad,
	output logic             done
);
	logic [1:0] half;
	logic       prev;
	initial begin
		word = 32'h0;
		bad  = 1'b0;
		done = 1'b0;
		forever begin
			@(posedge hclk);
			if (go) begin
				done = 1'b0;
				bad  = 1'b0;
				prev = 1'b0;
				for (int b = 31; b >= 0; b--) begin
					for (int h = 0; h < 2; h++) begin
						half[h] = load_mod;
						// Every clock of a half is sampled, so a short or long half shows.
						for (int k = 0; k <= rate; k++) begin
							if (load_mod !== half[h])
								bad = 1'b1;
							@(posedge hclk);
						end
					end
					case (mode)
						2'h1: begin
							word[b] = half[1];
							if (half[0] === half[1])
								bad = 1'b1;
						end
						2'h2: begin
							word[b] = (half[0] === half[1]);
							if (half[0] === prev)
								bad = 1'b1;
						end
						default: begin
							word[b] = half[1];
							if (half[0] !== half[1])
								bad = 1'b1;
						end
					endcase
					prev = half[1];
				end
				if (load_mod !== 1'b0)
					bad = 1'b1;
				done = 1'b1;
			end
		end
	end
endmodule : rtu_reader_model
`default_nettype wire

// file: sim/rtu_tag_uplink_encoder_tb.sv
// Purpose: Self-checking bench of the tag core over AHB-Lite with a reader on the coil side.
// Assumes: Zero wait states, which the cycle counts in t_init and send rely on; every wait is bounded.
// Notes:   Programming with good set feeds the block address and its CRC so the command check passes.
`timescale 1ns/100ps
`default_nettype none
`include "rtu_defs.svh"
`define RTU_CHK(a, e) \
	begin \
		n_checks++; \
		if ((a) !== (e)) begin \
			miscompares++; \
			$display("unexpected at %0t: got %h expected %h", $time, (a), (e)); \
		end \
	end
module rtu_tag_uplink_encoder_tb
	import rtu_pkg::*;
;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        irq;
	logic        load_mod;
	logic        go;
	logic [1:0]  mode;
	logic [4:0]  rate;
	logic [31:0] word;
	logic        bad;
	logic        done;
	logic [31:0] rd;
	int          miscompares;
	int          n_checks;

	rtu_tag_uplink_encoder u_rtu_tag_uplink_encoder (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .load_mod(load_mod)
	);
	rtu_reader_model u_rtu_reader_model (
		.hclk(hclk), .load_mod(load_mod), .go(go), .mode(mode), .rate(rate),
		.word(word), .bad(bad), .done(done)
	);

	always #4 hclk = ~hclk;

	task automatic report_and_stop();
		if (miscompares == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	task automatic wait_ready();
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		if (hreadyout !== 1'b1) begin
			miscompares++;
			report_and_stop();
		end
	endtask : wait_ready

	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		`RTU_CHK(rd & m, e)
	endtask : rdchk

	function automatic logic [15:0] crc_feed(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {b, 8'h0};
		for (int i = 0; i < 8; i++)
			r = r[15] ? ({r[14:0], 1'b0} ^ `RTU_CRC_POLY) : {r[14:0], 1'b0};
		return r;
	endfunction : crc_feed

	// Each call writes the CRC reset bit (bit 8) after the address and data writes, so each call starts from a fresh value.
	task automatic prog(input logic [5:0] blk, input logic [31:0] d, input logic lk,
			input logic good, input logic [31:0] ev);
		logic [15:0] c;
		c = crc_feed(`RTU_CRC_INIT, {2'h0, blk});
		wr(`RTU_A_CMD, {26'h0, blk});
		wr(`RTU_A_WDATA, d);
		wr(`RTU_A_CRC, 32'h100);
		if (good) begin
			wr(`RTU_A_CRC, {26'h0, blk});
			rdchk(`RTU_A_CRC, 32'hffff, {16'h0, c});
			wr(`RTU_A_CRC, {24'h0, c[15:8]});
			wr(`RTU_A_CRC, {24'h0, c[7:0]});
			rdchk(`RTU_A_STATUS, 32'h8, 32'h8);
		end
		wr(`RTU_A_CMD, {21'h0, lk, 4'h8, blk});
		rdchk(`RTU_A_ISTAT, 32'hf, ev);
		`RTU_CHK(irq, 1'b0)
		wr(`RTU_A_ISTAT, 32'hf);
	endtask : prog

	task automatic t_init();
		rdchk(`RTU_A_STATUS, 32'h1, 32'h0);
		repeat (196) @(posedge hclk);
		rdchk(`RTU_A_STATUS, 32'h1, 32'h0);
		rdchk(`RTU_A_STATUS, 32'h1, 32'h1);
		rdchk(`RTU_A_CFG, 32'h7f, 32'h0);
		rdchk(`RTU_A_SEC, 32'hffffffff, 32'h0);
		`RTU_CHK(load_mod, 1'b0)
		`RTU_CHK(hresp, 1'b0)
	endtask : t_init

	task automatic t_map();
		wr(`RTU_A_IMASK, 32'h1);
		rdchk(`RTU_A_IMASK, 32'hf, 32'h1);
		rdchk(8'h40, 32'hffffffff, 32'h0);
		prog(6'h28, 32'h1234_5678, 1'b0, 1'b1, 32'h4);
		rdchk(`RTU_A_RDATA, 32'hffffffff, 32'h0);
		prog(6'h10, 32'h1234_5678, 1'b0, 1'b0, 32'h2);
		rdchk(`RTU_A_RDATA, 32'hffffffff, 32'h0);
	endtask : t_map

	task automatic t_lock();
		prog(6'h07, 32'ha5a5_0f0f, 1'b1, 1'b1, 32'h8);
		rdchk(`RTU_A_STATUS, 32'h4, 32'h4);
		prog(6'h07, 32'h0, 1'b0, 1'b1, 32'h4);
		rdchk(`RTU_A_RDATA, 32'hffffffff, 32'ha5a5_0f0f);
		rdchk(`RTU_A_STATUS, 32'h4, 32'h4);
	endtask : t_lock

	task automatic send(input logic [1:0] m, input logic [4:0] n, input logic [31:0] d);
		int i;
		mode <= m;
		rate <= n;
		wr(`RTU_A_CFG, {25'h0, n, m});
		prog(6'h05, d, 1'b0, 1'b1, 32'h8);
		rdchk(`RTU_A_RDATA, 32'hffffffff, d);
		wr(`RTU_A_CMD, 32'h105);
		go <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
		// The reader clears done on the edge that takes go, so the wait starts one edge later.
		@(posedge hclk);
		for (i = 0; i < 3000 && done !== 1'b1; i++)
			@(posedge hclk);
		if (done !== 1'b1) begin
			miscompares++;
			report_and_stop();
		end
		@(posedge hclk);
		`RTU_CHK(word, d)
		`RTU_CHK(bad, 1'b0)
		`RTU_CHK(irq, 1'b1)
		wr(`RTU_A_ISTAT, 32'h1);
		@(posedge hclk);
		`RTU_CHK(irq, 1'b0)
	endtask : send

	initial begin
		hclk        = 1'b0;
		hresetn     = 1'b0;
		hsel        = 1'b0;
		haddr       = 32'h0;
		htrans      = 2'h0;
		hwrite      = 1'b0;
		hsize       = 3'h2;
		hwdata      = 32'h0;
		go          = 1'b0;
		mode        = 2'h0;
		rate        = 5'h0;
		miscompares = 0;
		n_checks    = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_init();
		t_map();
		t_lock();
		for (int m = 0; m < 4; m++) begin
			send(m[1:0], 5'h00, 32'hb4c3_5a0f);
			send(m[1:0], 5'h1f, 32'h6e91_d207);
		end
		report_and_stop();
	end
endmodule : rtu_tag_uplink_encoder_tb
`default_nettype wire
